// [hdl/pdc_pkg.sv]
/*
 * Package for the port direction and drive configuration block: register
 * addresses, reset values, field layouts and the carrier structs.
 * Assumes a byte-wide special-register access port from the processor core.
 */
package pdc_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] PDC_ADDR_PORT6_DIRECTION = 16'hff26;
  localparam logic [15:0] PDC_ADDR_PORT6_OUTPUT_TYPE = 16'hff2a;
  localparam logic [15:0] PDC_ADDR_PORT1_DIRECTION = 16'hff21;

  // ----------------------------------------------------------------
  // Reset values and fixed bits
  // ----------------------------------------------------------------
  localparam logic [7:0] PDC_RST_PORT6_DIRECTION = 8'hff;
  localparam logic [7:0] PDC_RST_PORT6_OUTPUT_TYPE = 8'h00;
  localparam logic [7:0] PDC_RST_PORT1_DIRECTION = 8'hff;
  localparam logic [7:0] PDC_RST_LATCH = 8'h00;
  localparam logic [1:0] PDC_P6_IMPL_MASK = 2'h3;
  localparam logic [5:0] PDC_P6_DIR_FIXED = 6'h3f;
  localparam logic [5:0] PDC_P6_OT_FIXED = 6'h00;
  localparam int PDC_P6_PINS = 2;
  localparam int PDC_P1_PINS = 8;
  localparam int PDC_P4_PINS = 3;
  localparam logic PDC_DIR_OUTPUT = 1'b0;
  localparam logic PDC_OT_OPEN_DRAIN = 1'b1;
  localparam logic PDC_RST_SERIAL_IN = 1'b1;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       bit_op;
    logic [2:0] bit_sel;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pdc_bus_s;

  typedef struct packed {
    logic clk_out;
    logic clk_oe;
    logic data_out;
    logic data_oe;
  } pdc_serial_s;

  typedef struct packed {
    logic [7:0] port1_direction_q;
    logic [1:0] port6_direction_q;
    logic [1:0] port6_output_type_q;
    logic [7:0] rdata_q;
    logic [PDC_P6_PINS-1:0] p6_out_q;
    logic [PDC_P6_PINS-1:0] p6_oe_q;
    logic [PDC_P1_PINS-1:0] p1_out_q;
    logic [PDC_P1_PINS-1:0] p1_oe_q;
    logic [PDC_P4_PINS-1:0] p4_oe_q;
    logic [PDC_P4_PINS-1:0] p4_out_q;
    logic p12_out_q;
    logic p12_oe_q;
    logic [PDC_P6_PINS-1:0] p6_sync1_q;
    logic [PDC_P6_PINS-1:0] p6_sync2_q;
    logic [PDC_P4_PINS-1:0] p4_sync1_q;
    logic [PDC_P4_PINS-1:0] p4_sync2_q;
    logic p12_sync1_q;
    logic p12_sync2_q;
    logic ss_clk_in_q;
    logic ss_data_in_q;
    logic ss_cs_in_q;
  } pdc_state_s;

endpackage

// [hdl/pdc_port_config.sv]
/*
 * Port direction and drive configuration: port 1 and port 6 direction,
 * port 6 output type, and pin routing of the second clocked serial channel.
 * Pads: push-pull gives enable 1 and the level; open drain gives enable as
 * the inverse level with the level held low; input mode releases the pad.
 * Pin levels reach the serial inputs after two sync stages and one register.
 * Assumes the core writes registers through a byte access port with optional
 * single-bit writes, and that output latches come from the port data logic.
 */
// Function
// - Direction bit 0 output, 1 input
// - Port 6 direction at ff26, resets ff
// - Output type 0 push-pull, 1 open-drain
// - Reset clears port 6 output type
// - Output type takes bit and byte writes
// - Output type at ff2a, bits 7-2 zero
// - Select 0 routes clock out and clock, data in to port 6; data out unrouted, chip select in from port 4 pin 2
// - Select 1 routes to ports 4, 12
// - Direction bits act independently per pin
`timescale 1ns/1ps
`default_nettype none
module pdc_port_config
  import pdc_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire pdc_bus_s bus, // Register access from core
  output logic [7:0] rdata, // Read data, registered
  input wire logic [7:0] port1_latch, // Port 1 output latch
  input wire logic [1:0] port6_latch, // Port 6 output latch
  input wire logic [2:0] port4_latch, // Port 4 pins 2..0 latch
  input wire logic [2:0] port4_direction, // Port 4 pins 2..0 direction
  input wire logic port12_latch, // Port 12 pin 0 latch
  input wire logic port12_direction, // Port 12 pin 0 direction
  input wire logic second_serial_pin_select, // Second channel pin select
  input wire logic first_serial_active, // First channel owns port 1 pins 0 and 2
  input wire logic second_serial_active, // Second channel owns its pins
  input wire pdc_serial_s first_serial, // First channel outputs
  input wire pdc_serial_s second_serial, // Second channel outputs
  output logic second_serial_clock_in, // Second channel clock input
  output logic second_serial_data_in, // Second channel data input
  output logic second_serial_chip_select_in, // Second channel chip select
  input wire logic [1:0] p6_pin_i, // Port 6 pin level
  output logic [1:0] p6_pin_o, // Port 6 pin drive level
  output logic [1:0] p6_pin_oe, // Port 6 pin drive enable
  output logic [7:0] p1_pin_o, // Port 1 pin drive level
  output logic [7:0] p1_pin_oe, // Port 1 pin drive enable
  input wire logic [2:0] p4_pin_i, // Port 4 pins 2..0 level
  output logic [2:0] p4_pin_o, // Port 4 pins 2..0 drive level
  output logic [2:0] p4_pin_oe, // Port 4 pins 2..0 drive enable
  input wire logic p12_pin_i, // Port 12 pin 0 level
  output logic p12_pin_o, // Port 12 pin 0 drive level
  output logic p12_pin_oe, // Port 12 pin 0 drive enable
  output logic [7:0] port1_direction, // Port 1 direction register
  output logic [1:0] port6_direction, // Port 6 direction bits
  output logic [1:0] port6_output_type // Port 6 output type bits
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte or single-bit write merged onto current contents
  function automatic logic [7:0] pdc_merge(input logic [7:0] cur, input pdc_bus_s b);
    logic [7:0] res;
    res = cur;
    if (b.bit_op)
    begin
      res[b.bit_sel] = b.wdata[0];
    end
    else
    begin
      res = b.wdata;
    end
    return res;
  endfunction

  // Pad drive: open-drain only pulls low, push-pull drives both levels
  function automatic logic [1:0] pdc_drive(input logic dir, input logic ot, input logic val);
    logic [1:0] res;
    res = 2'h0;
    if (dir == PDC_DIR_OUTPUT)
    begin
      if (ot == PDC_OT_OPEN_DRAIN)
      begin
        res = {~val, 1'b0};
      end
      else
      begin
        res = {1'b1, val};
      end
    end
    return res;
  endfunction

  // Second channel input: port 4 level when select is 1, else port 6
  function automatic logic pdc_pick(input logic sel, input logic alt, input logic dflt);
    logic res;
    res = dflt;
    if (sel)
    begin
      res = alt;
    end
    return res;
  endfunction

  pdc_state_s s_q;
  pdc_state_s s_d;
  logic [7:0] p6_dir_full;
  logic [7:0] p6_ot_full;
  logic [7:0] p6_dir_new;
  logic [7:0] p6_ot_new;
  logic [1:0] p6_src;
  logic [7:0] p1_src;
  logic [2:0] p4_src;
  logic p12_src;
  logic [1:0] drv;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    p6_dir_full = {PDC_P6_DIR_FIXED, s_q.port6_direction_q};
    p6_ot_full = {PDC_P6_OT_FIXED, s_q.port6_output_type_q};
    p6_dir_new = p6_dir_full;
    p6_ot_new = p6_ot_full;
    drv = 2'h0;

    // ----------------------------------------------------------------
    // Pin synchronisers, two stages per pad
    // ----------------------------------------------------------------
    s_d.p6_sync1_q = p6_pin_i;
    s_d.p6_sync2_q = s_q.p6_sync1_q;
    s_d.p4_sync1_q = p4_pin_i;
    s_d.p4_sync2_q = s_q.p4_sync1_q;
    s_d.p12_sync1_q = p12_pin_i;
    s_d.p12_sync2_q = s_q.p12_sync1_q;

    // ----------------------------------------------------------------
    // Second channel inputs, read from the second stage only
    // ----------------------------------------------------------------
    s_d.ss_clk_in_q = pdc_pick(second_serial_pin_select, s_q.p4_sync2_q[0], s_q.p6_sync2_q[0]);
    s_d.ss_data_in_q = pdc_pick(second_serial_pin_select, s_q.p4_sync2_q[1], s_q.p6_sync2_q[1]);
    s_d.ss_cs_in_q = s_q.p4_sync2_q[2];

    // ----------------------------------------------------------------
    // Register writes; fixed bits fall away
    // ----------------------------------------------------------------
    if (bus.wr)
    begin
      unique case (bus.addr)
        PDC_ADDR_PORT6_DIRECTION:
        begin
          p6_dir_new = pdc_merge(p6_dir_full, bus);
          s_d.port6_direction_q = p6_dir_new[1:0];
        end
        PDC_ADDR_PORT6_OUTPUT_TYPE:
        begin
          p6_ot_new = pdc_merge(p6_ot_full, bus);
          s_d.port6_output_type_q = p6_ot_new[1:0];
        end
        PDC_ADDR_PORT1_DIRECTION:
        begin
          s_d.port1_direction_q = pdc_merge(s_q.port1_direction_q, bus);
        end
        default:
        begin
          // Unmapped writes ignored
          s_d.rdata_q = s_q.rdata_q;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Register reads: old contents, unmapped reads zero
    // ----------------------------------------------------------------
    if (bus.rd)
    begin
      unique case (bus.addr)
        PDC_ADDR_PORT6_DIRECTION:
        begin
          s_d.rdata_q = p6_dir_full;
        end
        PDC_ADDR_PORT6_OUTPUT_TYPE:
        begin
          s_d.rdata_q = p6_ot_full;
        end
        PDC_ADDR_PORT1_DIRECTION:
        begin
          s_d.rdata_q = s_q.port1_direction_q;
        end
        default:
        begin
          s_d.rdata_q = 8'h00;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Output sources: latch, or peripheral when it owns the pin
    // ----------------------------------------------------------------
    p1_src = port1_latch;
    if (first_serial_active)
    begin
      p1_src[0] = first_serial.clk_out;
      p1_src[2] = first_serial.data_out;
    end
    p6_src = port6_latch;
    p4_src = port4_latch;
    p12_src = port12_latch;

    // ----------------------------------------------------------------
    // Second channel output routing
    // ----------------------------------------------------------------
    if (second_serial_active)
    begin
      if (second_serial_pin_select == 1'b0)
      begin
        p6_src[0] = second_serial.clk_out;
      end
      else
      begin
        p4_src[0] = second_serial.clk_out;
        p12_src = second_serial.data_out;
      end
    end

    // ----------------------------------------------------------------
    // Pin drive from direction and output type
    // ----------------------------------------------------------------
    // Port 1 pins are always push-pull
    for (int i = 0; i < PDC_P1_PINS; i++)
    begin
      drv = pdc_drive(s_q.port1_direction_q[i], 1'b0, p1_src[i]);
      s_d.p1_oe_q[i] = drv[1];
      s_d.p1_out_q[i] = drv[0];
    end
    for (int i = 0; i < PDC_P6_PINS; i++)
    begin
      drv = pdc_drive(s_q.port6_direction_q[i], s_q.port6_output_type_q[i], p6_src[i]);
      s_d.p6_oe_q[i] = drv[1];
      s_d.p6_out_q[i] = drv[0];
    end
    // Port 4 and 12 directions come from the port logic
    for (int i = 0; i < PDC_P4_PINS; i++)
    begin
      drv = pdc_drive(port4_direction[i], 1'b0, p4_src[i]);
      s_d.p4_oe_q[i] = drv[1];
      s_d.p4_out_q[i] = drv[0];
    end
    drv = pdc_drive(port12_direction, 1'b0, p12_src);
    s_d.p12_oe_q = drv[1];
    s_d.p12_out_q = drv[0];

    // ----------------------------------------------------------------
    // Reset
    // ----------------------------------------------------------------
    if (rst)
    begin
      s_d = '0;
      s_d.port6_direction_q = PDC_RST_PORT6_DIRECTION[1:0];
      s_d.port6_output_type_q = PDC_RST_PORT6_OUTPUT_TYPE[1:0];
      s_d.port1_direction_q = PDC_RST_PORT1_DIRECTION;
      s_d.ss_clk_in_q = PDC_RST_SERIAL_IN;
      s_d.ss_data_in_q = PDC_RST_SERIAL_IN;
      s_d.ss_cs_in_q = PDC_RST_SERIAL_IN;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata = s_q.rdata_q;
  assign p6_pin_o = s_q.p6_out_q;
  assign p6_pin_oe = s_q.p6_oe_q;
  assign p1_pin_o = s_q.p1_out_q;
  assign p1_pin_oe = s_q.p1_oe_q;
  assign p4_pin_o = s_q.p4_out_q;
  assign p4_pin_oe = s_q.p4_oe_q;
  assign p12_pin_o = s_q.p12_out_q;
  assign p12_pin_oe = s_q.p12_oe_q;
  assign port1_direction = s_q.port1_direction_q;
  assign port6_direction = s_q.port6_direction_q;
  assign port6_output_type = s_q.port6_output_type_q;
  assign second_serial_clock_in = s_q.ss_clk_in_q;
  assign second_serial_data_in = s_q.ss_data_in_q;
  assign second_serial_chip_select_in = s_q.ss_cs_in_q;

endmodule
`default_nettype wire

// [verification/pdc_checker.sv]
/* Assertion checker for the port configuration block.
   Sees only the top ports; attached by the bind at the foot. */
`timescale 1ns/1ps
`default_nettype none
module pdc_checker
  import pdc_pkg::*;
(
  input wire logic clock, // Clock
  input wire logic rst, // Reset
  input wire pdc_bus_s bus, // Register access
  input wire logic [7:0] rdata, // Read data
  input wire logic [1:0] port6_latch, // P6 latch
  input wire logic second_serial_pin_select, // Route select
  input wire logic second_serial_active, // Channel owns pins
  input wire logic [1:0] p6_pin_i, // P6 pad in
  input wire logic [2:0] p4_pin_i, // P4 pad in
  input wire logic second_serial_clock_in, // Routed clock
  input wire logic [1:0] p6_pin_o, // P6 drive
  input wire logic [1:0] p6_pin_oe, // P6 enable
  input wire logic [1:0] port6_direction, // P6 direction
  input wire logic [1:0] port6_output_type // P6 type
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence ot_wr_s;
    bus.wr && !bus.bit_op && bus.addr == PDC_ADDR_PORT6_OUTPUT_TYPE;
  endsequence
  reset_vals_a: assert property (
    $past(rst) |-> port6_direction == 2'h3 && port6_output_type == 2'h0) else $error("reset value wrong");
  ot_byte_a: assert property (
    ot_wr_s |=> port6_output_type == $past(bus.wdata[1:0])) else $error("type byte write lost");
  ot_bit_a: assert property (
    bus.wr && bus.bit_op && bus.addr == PDC_ADDR_PORT6_OUTPUT_TYPE && bus.bit_sel < 3'h2
    |=> port6_output_type[$past(bus.bit_sel[0])] == $past(bus.wdata[0])) else $error("type bit write lost");
  dir_byte_a: assert property (
    bus.wr && !bus.bit_op && bus.addr == PDC_ADDR_PORT6_DIRECTION
    |=> port6_direction == $past(bus.wdata[1:0])) else $error("direction write lost");
  rd_type_a: assert property (
    bus.rd && bus.addr == PDC_ADDR_PORT6_OUTPUT_TYPE |=> rdata == {6'h00, $past(port6_output_type)})
    else $error("type read wrong");
  rd_dir_a: assert property (
    bus.rd && bus.addr == PDC_ADDR_PORT6_DIRECTION |=> rdata == {6'h3f, $past(port6_direction)})
    else $error("direction read wrong");
  pin_drive_a: assert property (
    !$past(second_serial_active) |->
    p6_pin_oe[1] == (!$past(port6_direction[1]) && (!$past(port6_output_type[1]) || !$past(port6_latch[1])))
    && p6_pin_o[1] == (!$past(port6_direction[1]) && !$past(port6_output_type[1]) && $past(port6_latch[1])))
    else $error("pin drive wrong");
  clk_route_a: assert property (
    !$past(rst, 3) && !$past(rst, 2) && !$past(rst) |-> second_serial_clock_in ==
    ($past(second_serial_pin_select) ? $past(p4_pin_i[0], 3) : $past(p6_pin_i[0], 3)))
    else $error("clock route wrong");
endmodule
bind pdc_port_config pdc_checker chk_u (.clock, .rst, .bus, .rdata, .port6_latch, .second_serial_pin_select,
  .second_serial_active, .p6_pin_i, .p4_pin_i, .second_serial_clock_in, .p6_pin_o, .p6_pin_oe,
  .port6_direction, .port6_output_type);
`default_nettype wire

// [verification/tb.sv]
/* Testbench for the port configuration block: register access, pin drive, routing.
   Assumes the checker file is compiled beside it. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pdc_pkg::*;
  logic clock = 1'b0, rst = 1'b1, port12_latch = 1'b0, port12_direction = 1'b1, p12_pin_i = 1'b0;
  logic second_serial_pin_select = 1'b0, first_serial_active = 1'b0, second_serial_active = 1'b0;
  logic ss_clk_in, ss_data_in, ss_cs_in, p12_pin_o, p12_pin_oe;
  logic [7:0] rdata, p1_pin_o, p1_pin_oe, port1_direction, port1_latch = 8'h00;
  logic [1:0] p6_pin_o, p6_pin_oe, port6_direction, port6_output_type, port6_latch = 2'h0, p6_pin_i = 2'h0;
  logic [2:0] p4_pin_o, p4_pin_oe, port4_latch = 3'h0, port4_direction = 3'h7, p4_pin_i = 3'h0;
  pdc_bus_s bus = '0;
  pdc_serial_s first_serial = '0, second_serial = '0;
  int n_errors = 0, cmp_count = 0;
  pdc_port_config dut_u (.clock, .rst, .bus, .rdata, .port1_latch, .port6_latch, .port4_latch, .port4_direction,
    .port12_latch, .port12_direction, .second_serial_pin_select, .first_serial_active, .second_serial_active,
    .first_serial, .second_serial, .second_serial_clock_in(ss_clk_in), .second_serial_data_in(ss_data_in),
    .second_serial_chip_select_in(ss_cs_in), .p6_pin_i, .p6_pin_o, .p6_pin_oe, .p1_pin_o, .p1_pin_oe, .p4_pin_i,
    .p4_pin_o, .p4_pin_oe, .p12_pin_i, .p12_pin_o, .p12_pin_oe, .port1_direction, .port6_direction,
    .port6_output_type);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b, input logic [2:0] s);
    @(posedge clock);
    bus <= '{rd: 1'b0, wr: 1'b1, bit_op: b, bit_sel: s, addr: a, wdata: d};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clock);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clock);
    bus.rd <= 1'b0;
    @(negedge clock);
    chk(rdata, e);
  endtask
  task automatic settle();
    repeat (4) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic end_of_test();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial
  forever #50 clock = ~clock;
  initial
  begin
    #(100 * 3000);
    n_errors++;
    end_of_test();
  end
  initial
  begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(PDC_ADDR_PORT6_DIRECTION, 8'hff);
    rd(PDC_ADDR_PORT6_OUTPUT_TYPE, 8'h00);
    wr(PDC_ADDR_PORT6_OUTPUT_TYPE, 8'hff, 1'b0, 3'h0);
    rd(PDC_ADDR_PORT6_OUTPUT_TYPE, 8'h03);
    wr(PDC_ADDR_PORT6_OUTPUT_TYPE, 8'h00, 1'b1, 3'h0);
    wr(PDC_ADDR_PORT6_OUTPUT_TYPE, 8'h01, 1'b1, 3'h5);
    rd(PDC_ADDR_PORT6_OUTPUT_TYPE, 8'h02);
    wr(PDC_ADDR_PORT6_DIRECTION, 8'h01, 1'b0, 3'h0);
    rd(PDC_ADDR_PORT6_DIRECTION, 8'hfd);
    wr(16'hff27, 8'hff, 1'b0, 3'h0);
    rd(16'hff27, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      wr(PDC_ADDR_PORT6_DIRECTION, {8{i[0]}}, 1'b0, 3'h0);
      wr(PDC_ADDR_PORT6_OUTPUT_TYPE, {8{i[1]}}, 1'b0, 3'h0);
      port6_latch <= {2{i[2]}};
      settle();
      chk({6'h00, p6_pin_oe}, (i[0] || (i[1] && i[2])) ? 8'h00 : 8'h03);
      chk({6'h00, p6_pin_o}, (!i[0] && !i[1] && i[2]) ? 8'h03 : 8'h00);
    end
    wr(PDC_ADDR_PORT1_DIRECTION, 8'h5a, 1'b0, 3'h0);
    port1_latch <= 8'hff;
    settle();
    chk(p1_pin_oe, 8'ha5);
    chk(p1_pin_o, 8'ha5);
    chk(port1_direction, 8'h5a);
    @(posedge clock);
    first_serial_active <= 1'b1;
    first_serial <= 4'h2;
    port1_latch <= 8'hfb;
    settle();
    chk(p1_pin_o, 8'ha4);
    @(posedge clock);
    p6_pin_i <= 2'h2;
    p4_pin_i <= 3'h4;
    settle();
    chk({5'h00, ss_clk_in, ss_data_in, ss_cs_in}, 8'h03);
    @(posedge clock);
    second_serial_pin_select <= 1'b1;
    p6_pin_i <= 2'h1;
    p4_pin_i <= 3'h6;
    settle();
    chk({5'h00, ss_clk_in, ss_data_in, ss_cs_in}, 8'h03);
    @(posedge clock);
    second_serial_active <= 1'b1;
    second_serial <= 4'h2;
    port4_direction <= 3'h6;
    port4_latch <= 3'h1;
    port12_direction <= 1'b0;
    port12_latch <= 1'b0;
    settle();
    chk({4'h0, p4_pin_oe[0], p4_pin_o[0], p12_pin_oe, p12_pin_o}, 8'h0b);
    chk({5'h00, p4_pin_oe}, 8'h01);
    @(posedge clock);
    second_serial_pin_select <= 1'b0;
    wr(PDC_ADDR_PORT6_DIRECTION, 8'h00, 1'b0, 3'h0);
    wr(PDC_ADDR_PORT6_OUTPUT_TYPE, 8'h00, 1'b0, 3'h0);
    port6_latch <= 2'h1;
    settle();
    chk({7'h00, p6_pin_o[0]}, 8'h00);
    chk({6'h00, p6_pin_oe}, 8'h03);
    chk({6'h00, port6_output_type}, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
